/* shared/ccr_pkg.sv */
// Purpose: Shared constants and types for the CPU context registers
// Assumes: 8-bit data space, 12-bit program counter
// Notes:   Reset contents of data registers are a plain choice
`default_nettype none
package ccr_pkg;
	localparam logic [7:0]  ADDR_PTR_ONE     = 8'h80;
	localparam logic [7:0]  ADDR_PTR_TWO     = 8'h81;
	localparam logic [7:0]  ADDR_HOLD_FIRST  = 8'h82;
	localparam logic [7:0]  ADDR_HOLD_SECOND = 8'h83;
	localparam logic [7:0]  ADDR_ACC         = 8'hff;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [7:0]  DATA_ZERO        = 8'h00;
	localparam logic [11:0] PC_RESET_VEC     = 12'hffe;
	localparam logic [11:0] PC_ONE           = 12'h001;
	localparam int          PC_W             = 12;
	localparam int          BANK_W           = 2;
	localparam int          STACK_DEPTH      = 6;
	localparam logic [2:0]  DEPTH_FULL       = 3'h6;
	localparam logic [2:0]  DEPTH_EMPTY      = 3'h0;
	localparam logic [2:0]  DEPTH_ONE        = 3'h1;
	localparam logic [3:0]  MC_DIV_LAST      = 4'hc;
	localparam logic [3:0]  MC_DIV_START     = 4'h0;
	localparam logic [2:0]  MC_TWO           = 3'h2;
	localparam logic [2:0]  MC_FOUR          = 3'h4;
	localparam logic [2:0]  MC_FIVE          = 3'h5;
	localparam logic [2:0]  MC_LAST          = 3'h1;

	typedef enum logic [1:0] {
		CTX_NMI    = 2'b00,
		CTX_NORMAL = 2'b01,
		CTX_INT    = 2'b11
	} ccr_ctx_t;

	typedef enum logic [1:0] {
		LEN_TWO  = 2'h0,
		LEN_FOUR = 2'h1,
		LEN_FIVE = 2'h2
	} ccr_len_t;

	typedef enum logic [3:0] {
		OP_HOLD  = 4'h0,
		OP_INC   = 4'h1,
		OP_JUMP  = 4'h2,
		OP_CALL  = 4'h3,
		OP_REL   = 4'h4,
		OP_IRQ   = 4'h5,
		OP_NMI   = 4'h6,
		OP_RET   = 4'h7,
		OP_INTERRUPT_EXIT  = 4'h8
	} ccr_pc_op_t;

	typedef enum logic [2:0] {
		SEL_NONE, SEL_X, SEL_Y, SEL_V, SEL_W, SEL_ACC
	} ccr_sel_t;

	function automatic ccr_sel_t ccr_decode(input logic [7:0] addr);
		case (addr)
			ADDR_PTR_ONE:     ccr_decode = SEL_X;
			ADDR_PTR_TWO:     ccr_decode = SEL_Y;
			ADDR_HOLD_FIRST:  ccr_decode = SEL_V;
			ADDR_HOLD_SECOND: ccr_decode = SEL_W;
			ADDR_ACC:         ccr_decode = SEL_ACC;
			default:          ccr_decode = SEL_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

/* shared/ccr_flag_if.sv */
// Purpose: Carrier between the core and its banked flag pairs
// Assumes: One write port, acting on the active context only
// Notes:   None
`timescale 1ns/1ns
`default_nettype none
interface ccr_flag_if;
	import ccr_pkg::*;
	ccr_ctx_t ctx;
	logic     c_we;
	logic     z_we;
	logic     c_in;
	logic     z_in;
	logic     c_out;
	logic     z_out;
	modport core (output ctx, c_we, z_we, c_in, z_in, input c_out, z_out);
	modport bank (input ctx, c_we, z_we, c_in, z_in, output c_out, z_out);
endinterface
`default_nettype wire

/* src/ccr_flag_bank.sv */
// Purpose: Three carry/zero pairs, one per execution context
// Assumes: Context code is one of the three defined values
// Notes:   Pairs are never cleared by a context switch
`timescale 1ns/1ns
`default_nettype none
module ccr_flag_bank
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic SYS_CLK,
	input  wire logic RESETN,
	// Flag port
	ccr_flag_if.bank  fl
);
	localparam ccr_ctx_t CTXS [3] = '{CTX_NORMAL, CTX_INT, CTX_NMI};
	logic [2:0] c_q;
	logic [2:0] z_q;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_pair
			always_ff @(posedge SYS_CLK or negedge RESETN)
			begin
				if (!RESETN)
				begin
					c_q[g] <= 1'b0;
					z_q[g] <= 1'b0;
				end
				else if (fl.ctx == CTXS[g])
				begin
					if (fl.c_we)
						c_q[g] <= fl.c_in;
					if (fl.z_we)
						z_q[g] <= fl.z_in;
				end
			end
		end
	endgenerate

	always_comb
	begin
		case (fl.ctx)
			CTX_NORMAL:
			begin
				fl.c_out = c_q[0];
				fl.z_out = z_q[0];
			end
			CTX_INT:
			begin
				fl.c_out = c_q[1];
				fl.z_out = z_q[1];
			end
			default:
			begin
				fl.c_out = c_q[2];
				fl.z_out = z_q[2];
			end
		endcase
	end
endmodule // ccr_flag_bank
`default_nettype wire

/* src/ccr_ret_stack.sv */
// Purpose: Six-level LIFO of return addresses, no visible pointer
// Assumes: Push and pop never requested together
// Notes:   Saturates at both ends instead of wrapping
`timescale 1ns/1ns
`default_nettype none
module ccr_ret_stack
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RESETN,
	// Control
	input  wire logic              push,
	input  wire logic              pop,
	input  wire logic [PC_W-1:0]   push_pc,
	// State
	output logic      [PC_W-1:0]   top,
	output logic                   empty,
	output logic      [2:0]        depth
);
	logic [PC_W-1:0] lvl_q [STACK_DEPTH];
	logic [2:0]      depth_q;

	genvar g;
	generate
		for (g = 0; g < STACK_DEPTH; g++)
		begin : g_lvl
			always_ff @(posedge SYS_CLK or negedge RESETN)
			begin
				if (!RESETN)
					lvl_q[g] <= PC_RESET_VEC;
				else if (push)
					lvl_q[g] <= (g == 0) ? push_pc : lvl_q[(g == 0) ? 0 : g - 1];
				else if (pop && depth_q != DEPTH_EMPTY && g < STACK_DEPTH - 1)
					lvl_q[g] <= lvl_q[(g < STACK_DEPTH - 1) ? g + 1 : g];
			end
		end
	endgenerate

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			depth_q <= DEPTH_EMPTY;
		else if (push && depth_q != DEPTH_FULL)
			depth_q <= depth_q + DEPTH_ONE;
		else if (pop && depth_q != DEPTH_EMPTY)
			depth_q <= depth_q - DEPTH_ONE;
	end

	assign top   = lvl_q[0];
	assign empty = (depth_q == DEPTH_EMPTY);
	assign depth = depth_q;

	property p_depth_max;
		@(posedge SYS_CLK) disable iff (!RESETN)
		push && depth_q == DEPTH_FULL |=> depth_q == DEPTH_FULL;
	endproperty
	a_depth_max: assert property (p_depth_max) else $error("stack depth left full");
endmodule // ccr_ret_stack
`default_nettype wire

/* src/ccr_core.sv */
// Purpose: Programmer-visible registers, PC, flags and stack of the core
// Assumes: Requests are synchronous to SYS_CLK; one PC op per cycle
// Notes:   Machine cycle tick is SYS_CLK divided by thirteen
// Function
// - Accumulator is 8 bits, also reachable at data address FFh.
// - First and second pointers reachable at data addresses 80h and 81h.
// - Short-direct holding registers reachable at data addresses 82h and 83h.
// - Indirect addressing uses the selected pointer as operand address.
// - Program counter is 12 bits, covering 4096 bytes.
// - Beyond 4096 bytes, a bank switch value extends the program address.
// - Sequential execution increments the program counter by one.
// - Relative branch adds the signed offset to the program counter.
// - PC loads jump, call, vector, reset or popped address.
// - Three carry/zero pairs: normal, interrupt, non-maskable.
// - Interrupt entry switches pair; interrupt exit restores the previous pair.
// - Context switches never alter stored flag values.
// - Only the active context's pair is read or written.
// - Carry follows carry/borrow, tested bit, and feeds rotate left.
// - Zero set when the result is zero, else cleared.
// - After reset the non-maskable context and its pair are active.
// - Return stack has six 12-bit levels outside data space.
// - Call or interrupt shifts levels deeper, PC enters first level.
// - Return loads first level into PC and shifts levels up.
// - Beyond six nested pushes the stack stays deepest, oldest lost.
// - Return on empty stack leaves it unchanged; execution simply continues.
// - Instructions take two, four or five machine cycles.
`timescale 1ns/1ns
`default_nettype none
module ccr_core
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RESETN,
	// Data-space access
	input  wire logic [7:0]        DS_ADDR,
	input  wire logic              DS_WE,
	input  wire logic              DS_RE,
	input  wire logic [7:0]        DS_WDATA,
	output logic      [7:0]        DS_RDATA,
	output logic                   DS_HIT,
	// Indirect addressing
	input  wire logic              PTR_SEL,
	output logic      [7:0]        IND_ADDR,
	// Accumulator result port
	input  wire logic              ACC_WE,
	input  wire logic [7:0]        ACC_WDATA,
	output logic      [7:0]        ACC_OUT,
	// Program counter control
	input  wire ccr_pc_op_t        PC_OP,
	input  wire logic [PC_W-1:0]   PC_TARGET,
	input  wire logic [7:0]        REL_OFFSET,
	input  wire logic [PC_W-1:0]   VECTOR,
	input  wire logic [BANK_W-1:0] PROG_BANK,
	output logic      [PC_W-1:0]   PC_OUT,
	output logic [PC_W+BANK_W-1:0] PROG_ADDR,
	output logic      [2:0]        STACK_DEPTH_OUT,
	// Flags
	input  wire logic              FLAG_C_WE,
	input  wire logic              FLAG_C_IN,
	input  wire logic              FLAG_Z_WE,
	input  wire logic [7:0]        ALU_RESULT,
	output logic                   CARRY_OUT,
	output logic                   ZERO_OUT,
	output ccr_ctx_t               CTX_OUT,
	// Instruction timing
	input  wire logic              INSTR_START,
	input  wire ccr_len_t          INSTR_LEN,
	output logic                   INSTR_BUSY,
	output logic                   INSTR_DONE,
	output logic                   MC_TICK
);
	typedef enum logic {SEQ_IDLE = 1'b0, SEQ_RUN = 1'b1} ccr_seq_t;

	default clocking cb_sys @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);

	logic [7:0]      acc_q;
	logic [7:0]      x_q;
	logic [7:0]      y_q;
	logic [7:0]      v_q;
	logic [7:0]      w_q;
	logic [7:0]      rdata_q;
	logic            hit_q;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] rel_ext;
	logic [PC_W-1:0] rel_sum;
	ccr_ctx_t        ctx_q;
	ccr_ctx_t        hist0_q;
	ccr_ctx_t        hist1_q;
	ccr_sel_t        wr_sel;
	ccr_sel_t        rd_sel;
	logic            push;
	logic            pop;
	logic [PC_W-1:0] stk_top;
	logic            stk_empty;
	logic [2:0]      stk_depth;
	logic [3:0]      div_q;
	logic            tick;
	ccr_seq_t        seq_q;
	logic [2:0]      mc_left_q;
	logic            done_q;

	ccr_flag_if fl ();

	function automatic logic [2:0] len_cycles(input ccr_len_t len);
		case (len)
			LEN_TWO:  len_cycles = MC_TWO;
			LEN_FOUR: len_cycles = MC_FOUR;
			default:  len_cycles = MC_FIVE;
		endcase
	endfunction

	assign wr_sel = ccr_decode(DS_ADDR);
	assign rd_sel = ccr_decode(DS_ADDR);

	// Data-space writes; ALU result to the accumulator wins a collision
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			acc_q <= REG_RESET;
		else if (ACC_WE)
			acc_q <= ACC_WDATA;
		else if (DS_WE && wr_sel == SEL_ACC)
			acc_q <= DS_WDATA;
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			x_q <= REG_RESET;
			y_q <= REG_RESET;
			v_q <= REG_RESET;
			w_q <= REG_RESET;
		end
		else if (DS_WE)
		begin
			case (wr_sel)
				SEL_X:   x_q <= DS_WDATA;
				SEL_Y:   y_q <= DS_WDATA;
				SEL_V:   v_q <= DS_WDATA;
				SEL_W:   w_q <= DS_WDATA;
				default: ;
			endcase
		end
	end

	// Registered read; unmapped addresses answer zero with no hit
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rdata_q <= DATA_ZERO;
			hit_q   <= 1'b0;
		end
		else if (DS_RE)
		begin
			hit_q <= (rd_sel != SEL_NONE);
			case (rd_sel)
				SEL_X:   rdata_q <= x_q;
				SEL_Y:   rdata_q <= y_q;
				SEL_V:   rdata_q <= v_q;
				SEL_W:   rdata_q <= w_q;
				SEL_ACC: rdata_q <= acc_q;
				default: rdata_q <= DATA_ZERO;
			endcase
		end
		else
			hit_q <= 1'b0;
	end

	assign DS_RDATA = rdata_q;
	assign DS_HIT   = hit_q;
	assign ACC_OUT  = acc_q;
	assign IND_ADDR = PTR_SEL ? y_q : x_q;

	// Signed offset goes through the adder, result back to PC
	assign rel_ext = {{(PC_W - 8){REL_OFFSET[7]}}, REL_OFFSET};
	assign rel_sum = PC_W'(pc_q + rel_ext);

	assign push = (PC_OP == OP_CALL) || (PC_OP == OP_IRQ) || (PC_OP == OP_NMI);
	assign pop  = (PC_OP == OP_RET) || (PC_OP == OP_INTERRUPT_EXIT);

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			pc_q <= PC_RESET_VEC;
		else
		begin
			case (PC_OP)
				OP_INC:  pc_q <= PC_W'(pc_q + PC_ONE);
				OP_JUMP: pc_q <= PC_TARGET;
				OP_CALL: pc_q <= PC_TARGET;
				OP_REL:  pc_q <= rel_sum;
				OP_IRQ:  pc_q <= VECTOR;
				OP_NMI:  pc_q <= VECTOR;
				OP_RET, OP_INTERRUPT_EXIT:
				begin
					// Empty stack: PC already points at the next instruction
					if (!stk_empty)
						pc_q <= stk_top;
				end
				default: ;
			endcase
		end
	end

	assign PC_OUT    = pc_q;
	assign PROG_ADDR = {PROG_BANK, pc_q};

	ccr_ret_stack u_stack (
		.SYS_CLK (SYS_CLK),
		.RESETN  (RESETN),
		.push    (push),
		.pop     (pop),
		.push_pc (pc_q),
		.top     (stk_top),
		.empty   (stk_empty),
		.depth   (stk_depth)
	);
	assign STACK_DEPTH_OUT = stk_depth;

	// Context tracking; two history slots cover normal, interrupt, NMI nesting
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ctx_q   <= CTX_NMI;
			hist0_q <= CTX_NORMAL;
			hist1_q <= CTX_NORMAL;
		end
		else if (PC_OP == OP_IRQ || PC_OP == OP_NMI)
		begin
			ctx_q   <= (PC_OP == OP_IRQ) ? CTX_INT : CTX_NMI;
			hist0_q <= ctx_q;
			hist1_q <= hist0_q;
		end
		else if (PC_OP == OP_INTERRUPT_EXIT)
		begin
			ctx_q   <= hist0_q;
			hist0_q <= hist1_q;
			hist1_q <= CTX_NORMAL;
		end
	end

	assign fl.ctx  = ctx_q;
	assign fl.c_we = FLAG_C_WE;
	assign fl.c_in = FLAG_C_IN;
	assign fl.z_we = FLAG_Z_WE;
	assign fl.z_in = (ALU_RESULT == DATA_ZERO);

	ccr_flag_bank u_flags (
		.SYS_CLK (SYS_CLK),
		.RESETN  (RESETN),
		.fl      (fl.bank)
	);

	assign CARRY_OUT = fl.c_out;
	assign ZERO_OUT  = fl.z_out;
	assign CTX_OUT   = ctx_q;

	// Machine cycle divider, realigned at instruction start
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			div_q <= MC_DIV_START;
		else if ((INSTR_START && seq_q == SEQ_IDLE) || tick)
			div_q <= MC_DIV_START;
		else
			div_q <= div_q + 4'h1;
	end

	assign tick    = (div_q == MC_DIV_LAST);
	assign MC_TICK = tick;

	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			seq_q     <= SEQ_IDLE;
			mc_left_q <= MC_TWO;
			done_q    <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (seq_q)
				SEQ_IDLE:
				begin
					if (INSTR_START)
					begin
						seq_q     <= SEQ_RUN;
						mc_left_q <= len_cycles(INSTR_LEN);
					end
				end
				SEQ_RUN:
				begin
					if (tick)
					begin
						if (mc_left_q == MC_LAST)
						begin
							seq_q  <= SEQ_IDLE;
							done_q <= 1'b1;
						end
						else
							mc_left_q <= mc_left_q - 3'h1;
					end
				end
				default: seq_q <= SEQ_IDLE;
			endcase
		end
	end

	assign INSTR_BUSY = (seq_q == SEQ_RUN);
	assign INSTR_DONE = done_q;

	property p_acc_read;
		DS_RE && DS_ADDR == ADDR_ACC |=> DS_HIT && DS_RDATA == $past(acc_q);
	endproperty
	a_acc_read: assert property (p_acc_read) else $error("accumulator read wrong");
	property p_ptr_ind;
		DS_WE && DS_ADDR == ADDR_PTR_TWO && PTR_SEL |=> PTR_SEL |-> IND_ADDR == $past(DS_WDATA);
	endproperty
	a_ptr_ind: assert property (p_ptr_ind) else $error("indirect address stale");
	property p_hold_rw;
		DS_WE && DS_ADDR == ADDR_HOLD_FIRST ##1 DS_RE && DS_ADDR == ADDR_HOLD_FIRST && !DS_WE
		|=> DS_RDATA == $past(DS_WDATA, 2);
	endproperty
	a_hold_rw: assert property (p_hold_rw) else $error("holding register lost write");
	property p_inc;
		PC_OP == OP_INC |=> pc_q == PC_W'($past(pc_q) + PC_ONE);
	endproperty
	a_inc: assert property (p_inc) else $error("PC not incremented");
	property p_rel;
		PC_OP == OP_REL |=> pc_q == PC_W'($past(pc_q) + $past(rel_ext));
	endproperty
	a_rel: assert property (p_rel) else $error("relative branch wrong");
	property p_call;
		PC_OP == OP_CALL |=> pc_q == $past(PC_TARGET) && stk_top == $past(pc_q);
	endproperty
	a_call: assert property (p_call) else $error("call did not push PC");
	property p_ret_empty;
		PC_OP == OP_RET && stk_empty |=> pc_q == $past(pc_q) && stk_empty;
	endproperty
	a_ret_empty: assert property (p_ret_empty) else $error("return on empty moved PC");
	property p_irq_ctx;
		PC_OP == OP_IRQ ##1 PC_OP == OP_INTERRUPT_EXIT |=> ctx_q == $past(ctx_q, 2);
	endproperty
	a_irq_ctx: assert property (p_irq_ctx) else $error("context not restored");
	property p_zero;
		FLAG_Z_WE && PC_OP == OP_HOLD |=> ZERO_OUT == ($past(ALU_RESULT) == DATA_ZERO);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	// Done flop is set on the 26th edge, so it is first sampled high one edge later
	property p_two_mc;
		INSTR_START && seq_q == SEQ_IDLE && INSTR_LEN == LEN_TWO |-> ##27 INSTR_DONE;
	endproperty
	a_two_mc: assert property (p_two_mc) else $error("two-cycle instruction mistimed");

	c_call_ret: cover property (@(posedge SYS_CLK) PC_OP == OP_CALL ##1 PC_OP == OP_RET);
	c_irq_interrupt_exit: cover property (@(posedge SYS_CLK) PC_OP == OP_IRQ ##1 PC_OP == OP_INTERRUPT_EXIT);
	c_full: cover property (@(posedge SYS_CLK) stk_depth == DEPTH_FULL && push);
	c_done: cover property (@(posedge SYS_CLK) INSTR_DONE);
endmodule // ccr_core
`default_nettype wire

/* test/ccr_mem_model.sv */
// Purpose: Program memory beside the core, synchronous byte read
// Assumes: Contents are a fixed pattern of the program address
// Notes:   Read lags the address by one clock, so a new PC needs a cycle
`timescale 1ns/1ns
`default_nettype none
module ccr_mem_model
(
	// Clock
	input  wire logic        clk,
	// Program side
	input  wire logic [13:0] addr,
	output logic      [7:0]  rdata
);
	always_ff @(posedge clk)
	begin
		rdata <= addr[7:0] ^ addr[13:6];
	end
endmodule // ccr_mem_model
`default_nettype wire

/* test/cpu_context_registers_test.sv */
// Purpose: Self-checking bench for the core's registers, PC, flags, stack
// Assumes: Inputs change 5 ns after each rising edge
// Notes:   Relative offsets come from the program memory model
`timescale 1ns/1ns
`default_nettype none
module cpu_context_registers_test
	import ccr_pkg::*;
;
	logic                   clk, rst_n, ds_we, ds_re, ds_hit, ptr_sel, acc_we;
	logic                   c_we, c_in, z_we, carry, zero, i_start, busy, done, tick;
	logic [7:0]             ds_addr, ds_wdata, ds_rdata, ind_addr, acc_wdata, acc_out;
	logic [7:0]             rel_off, alu_res, r;
	ccr_pc_op_t             pc_op;
	ccr_len_t               len;
	ccr_ctx_t               ctx;
	logic [PC_W-1:0]        tgt, pc, e, v;
	logic [BANK_W-1:0]      bank;
	logic [PC_W+BANK_W-1:0] paddr;
	logic [2:0]             depth;
	logic [31:0]            seed;
	logic [7:0]             d [5];
	logic [PC_W-1:0]        t [7];
	int                     errors, cmp_count, cyc, k, n;
	logic [7:0] map [5] = '{ADDR_PTR_ONE, ADDR_PTR_TWO, ADDR_HOLD_FIRST,
		ADDR_HOLD_SECOND, ADDR_ACC};
	ccr_len_t   lens [3] = '{LEN_TWO, LEN_FOUR, LEN_FIVE};
	int         mcs [3] = '{2, 4, 5};

	ccr_core i_ccr_core (.SYS_CLK(clk), .RESETN(rst_n), .DS_ADDR(ds_addr), .DS_WE(ds_we),
		.DS_RE(ds_re), .DS_WDATA(ds_wdata), .DS_RDATA(ds_rdata), .DS_HIT(ds_hit),
		.PTR_SEL(ptr_sel), .IND_ADDR(ind_addr), .ACC_WE(acc_we), .ACC_WDATA(acc_wdata),
		.ACC_OUT(acc_out), .PC_OP(pc_op), .PC_TARGET(tgt), .REL_OFFSET(rel_off),
		.VECTOR(v), .PROG_BANK(bank), .PC_OUT(pc), .PROG_ADDR(paddr),
		.STACK_DEPTH_OUT(depth), .FLAG_C_WE(c_we), .FLAG_C_IN(c_in), .FLAG_Z_WE(z_we),
		.ALU_RESULT(alu_res), .CARRY_OUT(carry), .ZERO_OUT(zero), .CTX_OUT(ctx),
		.INSTR_START(i_start), .INSTR_LEN(len), .INSTR_BUSY(busy), .INSTR_DONE(done),
		.MC_TICK(tick));
	ccr_mem_model i_ccr_mem_model (.clk(clk), .addr(paddr), .rdata(rel_off));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// Sign-extended branch target, wraps within 4096 bytes
	function automatic logic [PC_W-1:0] f_rel(input logic [PC_W-1:0] p, input logic [7:0] o);
		return p + {{4{o[7]}}, o};
	endfunction

	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		cmp_count++;
		if (g !== x)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#5;
	endtask
	task automatic pcop(input ccr_pc_op_t o, input logic [PC_W-1:0] a);
		pc_op = o;
		tgt = a;
		v = a;
		step();
		pc_op = OP_HOLD;
		step();
	endtask
	task automatic ds_wr(input logic [7:0] a, input logic [7:0] w);
		ds_addr = a;
		ds_wdata = w;
		ds_we = 1'b1;
		step();
		ds_we = 1'b0;
		step();
	endtask
	task automatic ds_rd(input logic [7:0] a, input logic [7:0] x, input logic h);
		ds_addr = a;
		ds_re = 1'b1;
		step();
		ds_re = 1'b0;
		chk("ds_hit", h, ds_hit);
		chk("ds_rdata", x, ds_rdata);
		step();
	endtask
	task automatic flg(input logic c, input logic [7:0] res);
		c_we = 1'b1;
		c_in = c;
		z_we = 1'b1;
		alu_res = res;
		step();
		c_we = 1'b0;
		z_we = 1'b0;
		step();
	endtask
	task automatic ctxchk(input ccr_ctx_t x, input logic c, input logic z);
		chk("ctx", x, ctx);
		chk("carry", c, carry);
		chk("zero", z, zero);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		{rst_n, ds_we, ds_re, ptr_sel, acc_we, c_we, c_in, z_we, i_start} = '0;
		{ds_addr, ds_wdata, acc_wdata, alu_res, tgt, v, bank} = '0;
		pc_op = OP_HOLD;
		len = LEN_TWO;
		seed = 32'h98e48918;
		errors = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		#5 rst_n = 1'b1;
		chk("pc", PC_RESET_VEC, pc);
		ctxchk(CTX_NMI, 1'b0, 1'b0);
		chk("depth", DEPTH_EMPTY, depth);
		foreach (map[i]) ds_rd(map[i], REG_RESET, 1'b1);
		$display("test reset done");

		foreach (map[i])
		begin
			d[i] = 8'(rnd());
			ds_wr(map[i], d[i]);
		end
		foreach (map[i]) ds_rd(map[i], d[i], 1'b1);
		chk("acc_out", d[4], acc_out);
		ptr_sel = 1'b0;
		step();
		chk("ind_addr", d[0], ind_addr);
		ptr_sel = 1'b1;
		step();
		chk("ind_addr", d[1], ind_addr);
		d[1] = ~d[1];
		ds_wr(ADDR_PTR_TWO, d[1]);
		chk("ind_addr", d[1], ind_addr);
		ds_wr(8'h7f, 8'(rnd()));
		ds_rd(8'h7f, DATA_ZERO, 1'b0);
		ds_wr(8'h84, 8'(rnd()));
		ds_rd(8'h84, DATA_ZERO, 1'b0);
		// Write then read on consecutive edges
		d[2] = 8'(rnd());
		ds_wdata = d[2];
		ds_addr = ADDR_HOLD_FIRST;
		ds_we = 1'b1;
		step();
		ds_we = 1'b0;
		ds_rd(ADDR_HOLD_FIRST, d[2], 1'b1);
		// Same-cycle bus write to the accumulator loses to the ALU
		acc_wdata = 8'(rnd());
		ds_wdata = ~acc_wdata;
		ds_addr = ADDR_ACC;
		{acc_we, ds_we} = 2'b11;
		step();
		{acc_we, ds_we} = 2'b00;
		chk("acc_out", acc_wdata, acc_out);
		ds_rd(ADDR_ACC, acc_wdata, 1'b1);
		$display("test registers done");

		for (k = 0; k < 8; k++)
		begin
			bank = BANK_W'(rnd());
			e = PC_W'(rnd());
			pcop(OP_JUMP, e);
			chk("pc", e, pc);
			chk("prog_addr", {bank, e}, paddr);
			step();
			e = f_rel(e, rel_off);
			pcop(OP_REL, 12'h000);
			chk("pc", e, pc);
			pcop(OP_INC, 12'h000);
			chk("pc", PC_W'(e + PC_ONE), pc);
		end
		$display("test program_counter done");

		for (k = 0; k < 7; k++)
		begin
			t[k] = PC_W'(rnd());
			pcop(OP_CALL, t[k]);
			chk("pc", t[k], pc);
			chk("depth", (k < 6) ? k + 1 : 6, depth);
		end
		for (k = 5; k >= 0; k--)
		begin
			pcop(OP_RET, 12'h000);
			chk("pc", t[k], pc);
			chk("depth", k, depth);
		end
		pcop(OP_RET, 12'h000);
		chk("pc", t[0], pc);
		chk("depth", DEPTH_EMPTY, depth);
		$display("test stack done");

		flg(1'b1, DATA_ZERO);
		ctxchk(CTX_NMI, 1'b1, 1'b1);
		pcop(OP_INTERRUPT_EXIT, 12'h000);
		ctxchk(CTX_NORMAL, 1'b0, 1'b0);
		r = 8'(rnd()) | 8'h01;
		flg(1'b1, r);
		ctxchk(CTX_NORMAL, 1'b1, 1'b0);
		e = pc;
		pcop(OP_IRQ, PC_W'(rnd()));
		ctxchk(CTX_INT, 1'b0, 1'b0);
		chk("pc", v, pc);
		t[0] = v;
		flg(1'b0, DATA_ZERO);
		ctxchk(CTX_INT, 1'b0, 1'b1);
		pcop(OP_NMI, PC_W'(rnd()));
		ctxchk(CTX_NMI, 1'b1, 1'b1);
		chk("depth", 3'h2, depth);
		pcop(OP_INTERRUPT_EXIT, 12'h000);
		ctxchk(CTX_INT, 1'b0, 1'b1);
		chk("pc", t[0], pc);
		pcop(OP_INTERRUPT_EXIT, 12'h000);
		ctxchk(CTX_NORMAL, 1'b1, 1'b0);
		chk("pc", e, pc);
		// Back-to-back call/return and interrupt/exit, no idle cycle between
		tgt = PC_W'(rnd());
		pc_op = OP_CALL;
		step();
		pc_op = OP_RET;
		step();
		chk("pc", e, pc);
		pc_op = OP_IRQ;
		step();
		pc_op = OP_INTERRUPT_EXIT;
		step();
		pc_op = OP_HOLD;
		step();
		ctxchk(CTX_NORMAL, 1'b1, 1'b0);
		chk("pc", e, pc);
		chk("depth", DEPTH_EMPTY, depth);
		$display("test flags done");

		foreach (lens[i])
		begin
			len = lens[i];
			i_start = 1'b1;
			step();
			i_start = 1'b0;
			chk("busy", 1'b1, busy);
			k = 0;
			n = 0;
			while (done !== 1'b1 && k < 100)
			begin
				step();
				k++;
				n += tick;
				i_start = (k == 3);
			end
			chk("done_cycles", 16'(13 * mcs[i]), k[15:0]);
			chk("mc_ticks", 16'(mcs[i]), n[15:0]);
			chk("busy", 1'b0, busy);
			step();
		end
		$display("test timing done");
		end_of_test();
	end
endmodule // cpu_context_registers_test
`default_nettype wire
